// ---- core/dsw_pkg.sv ----
// Shared types and constants for the drive status word composer.
// Assumes one drive clock domain and a synchronous active-high reset.
package dsw_pkg;

	// Object indexes reached through the object access port.
	localparam logic [15:0] IDX_TORQUE_LIMIT_FLAG_SELECT = 16'h3703;
	localparam logic [15:0] IDX_DRIVE_STATUS_WORD        = 16'h6041;

	// Reset values.
	localparam logic        RST_TORQUE_LIMIT_FLAG_SELECT = 1'h0;
	localparam logic [15:0] RST_DRIVE_STATUS_WORD        = 16'h0000;

	// Status word field positions.
	localparam int BIT_READY_TO_SWITCH_ON = 0;
	localparam int BIT_SWITCHED_ON        = 1;
	localparam int BIT_OPERATION_ENABLED  = 2;
	localparam int BIT_FAULT              = 3;
	localparam int BIT_VOLTAGE_APPLIED    = 4;
	localparam int BIT_QUICKHALT          = 5;
	localparam int BIT_SWITCH_ON_DISABLED = 6;
	localparam int BIT_WARNING            = 7;
	localparam int BIT_RESERVED8          = 8;
	localparam int BIT_REMOTE             = 9;
	localparam int BIT_MODE_A             = 10;
	localparam int BIT_INTERNAL_LIMIT     = 11;
	localparam int BIT_MODE_B             = 12;
	localparam int BIT_MODE_C             = 13;
	localparam int BIT_RESERVED14         = 14;
	localparam int BIT_RESERVED15         = 15;

	// Second torque limit takes part only for these selector values.
	localparam logic [15:0] TL2_SELECT_A = 16'h0002;
	localparam logic [15:0] TL2_SELECT_B = 16'h0004;

	// Flag select values.
	localparam logic [15:0] FLAG_SEL_INCLUDE = 16'h0000;
	localparam logic [15:0] FLAG_SEL_EXCLUDE = 16'h0001;

	typedef enum logic [2:0] {
		PWR_NOT_READY,
		PWR_SWITCH_ON_DISABLED,
		PWR_READY_TO_SWITCH_ON,
		PWR_SWITCHED_ON,
		PWR_OPERATION_ENABLED,
		PWR_QUICK_STOP_ACTIVE,
		PWR_FAULT_REACTION,
		PWR_FAULT
	} dsw_power_drive_state_e;

	// Ordered so that a plain comparison tells pre-operational or higher.
	typedef enum logic [1:0] {
		COMM_INIT,
		COMM_PRE_OPERATIONAL,
		COMM_SAFE_OPERATIONAL,
		COMM_OPERATIONAL
	} dsw_comm_state_machine_e;

	typedef enum logic [3:0] {
		MODE_NONE,
		MODE_PROFILE_POSITION,
		MODE_PROFILE_VELOCITY,
		MODE_PROFILE_TORQUE,
		MODE_HOMING,
		MODE_INTERPOLATED_POSITION,
		MODE_CYCLIC_POSITION,
		MODE_CYCLIC_VELOCITY,
		MODE_CYCLIC_TORQUE
	} dsw_mode_e;

	// Per-mode event flags from the motion logic.
	typedef struct packed {
		logic following_error;
		logic setpoint_ack;
		logic target_reached;
		logic homing_error;
		logic homing_attained;
		logic speed_flag;
		logic interp_active;
		logic follows_command;
	} dsw_motion_flags_s;

	// Limit detector levels.
	typedef struct packed {
		logic emergency_stop;
		logic estop_torque_limited;
		logic positive_travel_inhibit;
		logic negative_travel_inhibit;
		logic software_limit;
		logic direction_setup_limit;
	} dsw_limit_flags_s;

	// Torque figures; target and offset are signed, limits are magnitudes.
	typedef struct packed {
		logic signed [15:0] target_torque;
		logic signed [15:0] torque_offset;
		logic [15:0]        max_torque;
		logic [15:0]        torque_limit1;
		logic [15:0]        torque_limit2;
		logic [15:0]        tl2_select;
		logic [15:0]        torque_demand;
	} dsw_torque_s;

endpackage : dsw_pkg

// ---- core/dsw_composer.sv ----
// Drive status word composer: builds the read-only status word each cycle.
// Assumes all inputs are synchronous to clock and come from the drive's own
// state machines, alarm logic, limit detectors and communication logic.
//
// Behaviour
// - Status word is a 16-bit read-only value, valid in every mode.
// - Initialisation pending: bit6 zero, bits 3 to 0 zero.
// - Switch-on inhibited: bit6 one, bits 3 to 0 zero.
// - Ready to switch on: bits 6,5 are 01, bits 3 to 0 are 0001.
// - Switched on: bits 6,5 are 01, bits 3 to 0 are 0011.
// - Operation enabled: bits 6,5 are 01, bits 3 to 0 are 0111.
// - Quick stop active: bits 6,5 are 00, bits 3 to 0 are 0111.
// - Fault reaction: bit6 zero, bits 3 to 0 are 1111.
// - Fault settled: bit6 zero, bits 3 to 0 are 1000.
// - Bit4 follows main circuit voltage presence.
// - Bit5 is active low: zero while quick stop responds.
// - Bit7 shows a warning without touching state or motion.
// - Bit8 always reads zero.
// - Bit9 set once communication reaches pre-operational or higher.
// - Profile position and homing modes use bits 13, 12, 10 for their events; interpolated position uses 12 and 10.
// - Velocity mode uses bits 12 and 10; torque profile only bit10.
// - Cyclic modes set bit12 when following; cyclic position uses bit13.
// - Bit11 set while an internal limit of the current mode is active.
// - Per-mode limit factors, some only with servo on.
// - Emergency stop without torque limiting is no limit factor.
// - Zero effective torque limit sets bit11 even with servo off, except in interpolated position mode or with no mode.
// - Effective torque limit is the minimum of the listed sources.
// - Flag select chooses whether torque command joins the limit judgement.
// - Bits 15 and 14 always read zero.
`timescale 1ns/1ps

module dsw_composer (
	input  wire logic                             clock,
	input  wire logic                             srst,
	input  wire dsw_pkg::dsw_power_drive_state_e  power_drive_state,
	input  wire dsw_pkg::dsw_comm_state_machine_e comm_state_machine,
	input  wire dsw_pkg::dsw_mode_e               control_mode,
	input  wire logic                             servo_on,
	input  wire logic                             main_power_present,
	input  wire logic                             warning_present,
	input  wire dsw_pkg::dsw_motion_flags_s       motion_flags,
	input  wire dsw_pkg::dsw_limit_flags_s        limit_flags,
	input  wire dsw_pkg::dsw_torque_s             torque,
	input  wire logic                             obj_req,
	input  wire logic                             obj_wr,
	input  wire logic [15:0]                      obj_index,
	input  wire logic [15:0]                      obj_wdata,
	output logic                                  obj_ack,
	output logic                                  obj_err,
	output logic [15:0]                           obj_rdata,
	output logic [15:0]                           drive_status_word,
	output logic                                  torque_limit_flag_select
);

	logic [15:0] status_ff;
	logic [15:0] nxt_status;
	logic        flag_sel_ff;
	logic        obj_ack_ff;
	logic        obj_err_ff;
	logic [15:0] obj_rdata_ff;

	logic [3:0]  state_low;
	logic        state_sod;
	logic        quickhalt_n;
	logic        mode_a;
	logic        mode_b;
	logic        mode_c;
	logic        remote;
	logic        internal_limit;

	logic        is_position;
	logic        is_homing;
	logic        is_velocity;
	logic        is_torque;

	logic [16:0] cmd_sum;
	logic [15:0] cmd_mag;
	logic [15:0] lim_base;
	logic [15:0] lim_with_cmd;
	logic [15:0] lim_for_flag;
	logic [15:0] lim_effective;
	logic        tl2_used;
	logic        torque_limited;
	logic        torque_zero;
	logic        estop_factor;
	logic        travel_factor;

	always_comb begin
		state_low   = 4'h0;
		state_sod   = 1'b0;
		quickhalt_n = 1'b0;
		unique case (power_drive_state)
			dsw_pkg::PWR_NOT_READY: begin
				state_low = 4'h0;
			end
			dsw_pkg::PWR_SWITCH_ON_DISABLED: begin
				state_sod = 1'b1;
				state_low = 4'h0;
			end
			dsw_pkg::PWR_READY_TO_SWITCH_ON: begin
				quickhalt_n = 1'b1;
				state_low   = 4'h1;
			end
			dsw_pkg::PWR_SWITCHED_ON: begin
				quickhalt_n = 1'b1;
				state_low   = 4'h3;
			end
			dsw_pkg::PWR_OPERATION_ENABLED: begin
				quickhalt_n = 1'b1;
				state_low   = 4'h7;
			end
			dsw_pkg::PWR_QUICK_STOP_ACTIVE: begin
				quickhalt_n = 1'b0;
				state_low   = 4'h7;
			end
			dsw_pkg::PWR_FAULT_REACTION: begin
				state_low = 4'hF;
			end
			dsw_pkg::PWR_FAULT: begin
				state_low = 4'h8;
			end
		endcase
	end

	assign remote = (comm_state_machine >= dsw_pkg::COMM_PRE_OPERATIONAL);

	assign is_position = (control_mode == dsw_pkg::MODE_PROFILE_POSITION) ||
		(control_mode == dsw_pkg::MODE_CYCLIC_POSITION);
	assign is_homing   = (control_mode == dsw_pkg::MODE_HOMING);
	assign is_velocity = (control_mode == dsw_pkg::MODE_PROFILE_VELOCITY) ||
		(control_mode == dsw_pkg::MODE_CYCLIC_VELOCITY);
	assign is_torque   = (control_mode == dsw_pkg::MODE_PROFILE_TORQUE) ||
		(control_mode == dsw_pkg::MODE_CYCLIC_TORQUE);

	always_comb begin
		mode_a = 1'b0;
		mode_b = 1'b0;
		mode_c = 1'b0;
		unique case (control_mode)
			dsw_pkg::MODE_PROFILE_POSITION: begin
				mode_c = motion_flags.following_error;
				mode_b = motion_flags.setpoint_ack;
				mode_a = motion_flags.target_reached;
			end
			dsw_pkg::MODE_HOMING: begin
				mode_c = motion_flags.homing_error;
				mode_b = motion_flags.homing_attained;
				mode_a = motion_flags.target_reached;
			end
			dsw_pkg::MODE_PROFILE_VELOCITY: begin
				mode_b = motion_flags.speed_flag;
				mode_a = motion_flags.target_reached;
			end
			dsw_pkg::MODE_PROFILE_TORQUE: begin
				mode_a = motion_flags.target_reached;
			end
			dsw_pkg::MODE_INTERPOLATED_POSITION: begin
				mode_b = motion_flags.interp_active;
				mode_a = motion_flags.target_reached;
			end
			dsw_pkg::MODE_CYCLIC_POSITION: begin
				mode_c = motion_flags.following_error;
				mode_b = motion_flags.follows_command;
			end
			dsw_pkg::MODE_CYCLIC_VELOCITY,
			dsw_pkg::MODE_CYCLIC_TORQUE: begin
				mode_b = motion_flags.follows_command;
			end
			dsw_pkg::MODE_NONE: begin
				mode_a = 1'b0;
			end
			// Codes past the last mode are illegal and leave every mode bit clear.
			default: begin
				mode_a = 1'b0;
			end
		endcase
	end

	// Torque limit sources.
	// A negative command still limits by its size, so its magnitude is used.
	assign cmd_sum  = {torque.target_torque[15], torque.target_torque} +
		{torque.torque_offset[15], torque.torque_offset};
	assign cmd_mag  = cmd_sum[16] ? ((~cmd_sum[15:0]) + 16'h0001) : cmd_sum[15:0];
	assign tl2_used = !is_torque && ((torque.tl2_select == dsw_pkg::TL2_SELECT_A) ||
		(torque.tl2_select == dsw_pkg::TL2_SELECT_B));

	always_comb begin
		lim_base = torque.max_torque;
		if (torque.torque_limit1 < lim_base) begin
			lim_base = torque.torque_limit1;
		end
		if (tl2_used && (torque.torque_limit2 < lim_base)) begin
			lim_base = torque.torque_limit2;
		end
	end

	assign lim_with_cmd = (is_torque && (cmd_mag < lim_base)) ? cmd_mag : lim_base;
	assign lim_effective = lim_with_cmd;

	assign lim_for_flag = (is_torque && flag_sel_ff) ? lim_base : lim_with_cmd;

	assign torque_limited = (torque.torque_demand >= lim_for_flag);

	assign torque_zero = (lim_effective == 16'h0000);

	assign estop_factor = limit_flags.emergency_stop && limit_flags.estop_torque_limited;

	assign travel_factor = limit_flags.positive_travel_inhibit ||
		limit_flags.negative_travel_inhibit;

	always_comb begin
		internal_limit = 1'b0;
		if (is_position || is_homing || is_velocity || is_torque) begin
			internal_limit = (servo_on && (estop_factor || torque_limited)) || torque_zero;
			if (is_position || is_velocity || is_torque) begin
				internal_limit = internal_limit || travel_factor;
			end
			if (is_position) begin
				internal_limit = internal_limit || limit_flags.software_limit;
			end
			if (is_torque) begin
				internal_limit = internal_limit ||
					(servo_on && limit_flags.direction_setup_limit);
			end
		end
	end

	always_comb begin
		nxt_status = 16'h0000;
		nxt_status[3:0] = state_low;
		nxt_status[dsw_pkg::BIT_VOLTAGE_APPLIED] = main_power_present;
		nxt_status[dsw_pkg::BIT_QUICKHALT] = quickhalt_n;
		nxt_status[dsw_pkg::BIT_SWITCH_ON_DISABLED] = state_sod;
		nxt_status[dsw_pkg::BIT_WARNING] = warning_present;
		nxt_status[dsw_pkg::BIT_RESERVED8] = 1'b0;
		nxt_status[dsw_pkg::BIT_REMOTE] = remote;
		nxt_status[dsw_pkg::BIT_MODE_A] = mode_a;
		nxt_status[dsw_pkg::BIT_INTERNAL_LIMIT] = internal_limit;
		nxt_status[dsw_pkg::BIT_MODE_B] = mode_b;
		nxt_status[dsw_pkg::BIT_MODE_C] = mode_c;
		nxt_status[dsw_pkg::BIT_RESERVED14] = 1'b0;
		nxt_status[dsw_pkg::BIT_RESERVED15] = 1'b0;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			status_ff <= dsw_pkg::RST_DRIVE_STATUS_WORD;
		end else begin
			status_ff <= nxt_status;
		end
	end

	// Only zero and one are legal for the flag select; anything else is refused.
	always_ff @(posedge clock) begin
		if (srst) begin
			flag_sel_ff <= dsw_pkg::RST_TORQUE_LIMIT_FLAG_SELECT;
		end else if (obj_req && obj_wr && (obj_index == dsw_pkg::IDX_TORQUE_LIMIT_FLAG_SELECT)
			&& (obj_wdata <= dsw_pkg::FLAG_SEL_EXCLUDE)) begin
			flag_sel_ff <= obj_wdata[0];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			obj_ack_ff   <= 1'b0;
			obj_err_ff   <= 1'b0;
			obj_rdata_ff <= 16'h0000;
		end else begin
			obj_ack_ff <= obj_req;
			obj_err_ff <= 1'b0;
			if (obj_req) begin
				obj_rdata_ff <= 16'h0000;
				if (obj_index == dsw_pkg::IDX_DRIVE_STATUS_WORD) begin
					obj_rdata_ff <= status_ff;
					obj_err_ff   <= obj_wr;
				end else if (obj_index == dsw_pkg::IDX_TORQUE_LIMIT_FLAG_SELECT) begin
					obj_rdata_ff <= {15'h0000, flag_sel_ff};
					obj_err_ff   <= obj_wr && (obj_wdata > dsw_pkg::FLAG_SEL_EXCLUDE);
				end else begin
					obj_err_ff <= 1'b1;
				end
			end
		end
	end

	assign obj_ack                  = obj_ack_ff;
	assign obj_err                  = obj_err_ff;
	assign obj_rdata                = obj_rdata_ff;
	assign drive_status_word        = status_ff;
	assign torque_limit_flag_select = flag_sel_ff;

endmodule : dsw_composer

// ---- sim/dsw_properties.sv ----
// Checker for the status word composer, watching its ports only.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module dsw_properties (
	input wire logic                             clock,
	input wire logic                             srst,
	input wire dsw_pkg::dsw_power_drive_state_e  power_drive_state,
	input wire dsw_pkg::dsw_comm_state_machine_e comm_state_machine,
	input wire logic                             main_power_present,
	input wire logic                             warning_present,
	input wire logic                             obj_req,
	input wire logic                             obj_wr,
	input wire logic [15:0]                      obj_index,
	input wire logic                             obj_ack,
	input wire logic                             obj_err,
	input wire logic [15:0]                      drive_status_word
);
	logic [5:0] state_bits;

	// Bits 6, 5 and 3 to 0 gathered so each state reads as one figure.
	assign state_bits = {drive_status_word[6:5], drive_status_word[3:0]};

	default clocking dc @(posedge clock);
	endclocking
	default disable iff (srst);

	reset_clear_a: assert property (disable iff (1'h0)
		srst |=> drive_status_word == 16'h0000) else $error("word not clear after reset");
	voltage_flag_a: assert property (
		!$past(srst) |-> drive_status_word[4] == $past(main_power_present))
		else $error("voltage flag wrong");
	warning_flag_a: assert property (
		!$past(srst) |-> drive_status_word[7] == $past(warning_present))
		else $error("warning flag wrong");
	remote_flag_a: assert property (
		!$past(srst) |->
		drive_status_word[9] == ($past(comm_state_machine) != dsw_pkg::COMM_INIT))
		else $error("remote flag wrong");
	reserved_zero_a: assert property (
		drive_status_word[15:14] == 2'h0 && !drive_status_word[8])
		else $error("reserved bit set");
	op_enabled_a: assert property (
		!$past(srst) && $past(power_drive_state) == dsw_pkg::PWR_OPERATION_ENABLED
		|-> state_bits == 6'h17) else $error("enabled state bits wrong");
	quick_stop_a: assert property (
		!$past(srst) && $past(power_drive_state) == dsw_pkg::PWR_QUICK_STOP_ACTIVE
		|-> state_bits == 6'h07) else $error("quick stop bits wrong");
	fault_react_a: assert property (
		!$past(srst) && $past(power_drive_state) == dsw_pkg::PWR_FAULT_REACTION
		|-> (state_bits & 6'h2F) == 6'h0F) else $error("fault reaction bits wrong");
	obj_answer_a: assert property (
		!$past(srst) |-> obj_ack == $past(obj_req)) else $error("object answer late");
	ro_write_a: assert property (
		obj_req && obj_wr && obj_index == dsw_pkg::IDX_DRIVE_STATUS_WORD |=> obj_err)
		else $error("status word write accepted");
endmodule : dsw_properties

// ---- sim/dsw_master_model.sv ----
// Fieldbus master model: object accesses and watch of the process data.
// Assumes the composer's one-cycle request pulse and registered answer.
`timescale 1ns/1ps
module dsw_master_model (
	input  wire logic        clock,
	input  wire logic        obj_ack,
	input  wire logic        obj_err,
	input  wire logic [15:0] obj_rdata,
	input  wire logic [15:0] drive_status_word,
	output logic             obj_req,
	output logic             obj_wr,
	output logic [15:0]      obj_index,
	output logic [15:0]      obj_wdata,
	output logic             cmd_allowed,
	output logic [15:0]      ctrl_word
);
	assign cmd_allowed = drive_status_word[9];

	// Command word coding.
	// Halt and fault reset stay low; bits 3 to 0 ask for enable operation once remote.
	assign ctrl_word = cmd_allowed ? 16'h000F : 16'h0000;

	initial begin
		obj_req = 1'h0;
		obj_wr = 1'h0;
		obj_index = 16'h0000;
		obj_wdata = 16'h0000;
	end

	task automatic access(input logic w, input logic [15:0] i, input logic [15:0] d,
		output logic a, output logic e, output logic [15:0] r);
		@(posedge clock);
		obj_req <= 1'h1;
		obj_wr <= w;
		obj_index <= i;
		obj_wdata <= d;
		@(posedge clock);
		obj_req <= 1'h0;
		// Released lines show the inverse so a stale value is never trusted.
		obj_index <= ~i;
		obj_wdata <= ~d;
		#1;
		a = obj_ack;
		e = obj_err;
		r = obj_rdata;
	endtask : access
endmodule : dsw_master_model

// ---- sim/tb_top.sv ----
// Testbench for the status word composer driven by a fieldbus master model.
// Assumes both share one 20 MHz clock; the checker is bound at the foot.
`timescale 1ns/1ps
module tb_top;
	logic                             clock;
	logic                             srst;
	logic                             servo;
	logic                             mpow;
	logic                             warn;
	dsw_pkg::dsw_power_drive_state_e  pwr;
	dsw_pkg::dsw_comm_state_machine_e comm;
	dsw_pkg::dsw_mode_e               mode;
	dsw_pkg::dsw_motion_flags_s       mf;
	dsw_pkg::dsw_limit_flags_s        lf;
	dsw_pkg::dsw_torque_s             trq;
	logic                             req;
	logic                             wr;
	logic [15:0]                      idx;
	logic [15:0]                      wd;
	logic                             ack;
	logic                             err;
	logic [15:0]                      rdat;
	logic [15:0]                      dsw;
	logic                             fsel;
	logic [15:0]                      cw;
	int                               n_mismatch;
	int                               samples_checked;

	dsw_composer dut (.clock(clock), .srst(srst), .power_drive_state(pwr),
		.comm_state_machine(comm), .control_mode(mode), .servo_on(servo),
		.main_power_present(mpow), .warning_present(warn), .motion_flags(mf),
		.limit_flags(lf), .torque(trq), .obj_req(req), .obj_wr(wr), .obj_index(idx),
		.obj_wdata(wd), .obj_ack(ack), .obj_err(err), .obj_rdata(rdat),
		.drive_status_word(dsw), .torque_limit_flag_select(fsel));
	dsw_master_model mst (.clock(clock), .obj_ack(ack), .obj_err(err), .obj_rdata(rdat),
		.drive_status_word(dsw), .obj_req(req), .obj_wr(wr), .obj_index(idx),
		.obj_wdata(wd), .cmd_allowed(), .ctrl_word(cw));

	always #25 clock = ~clock;

	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			$display("[FAIL] %s expected %h seen %h", what, e, g);
			n_mismatch++;
		end
	endtask : chk

	task automatic tick;
		@(posedge clock);
		#1;
	endtask : tick

	task automatic t_reset;
		@(posedge clock);
		srst <= 1'h1;
		repeat (2) @(posedge clock);
		srst <= 1'h0;
		#1;
		chk("reset word", 16'h0000, dsw);
		chk("reset select", 16'h0000, {15'h0000, fsel});
		$display("reset test done");
	endtask : t_reset

	task automatic st(input dsw_pkg::dsw_power_drive_state_e s, input logic [5:0] e);
		@(posedge clock);
		pwr <= s;
		tick();
		chk("state bits", {10'h000, e}, {10'h000, dsw[6:5], dsw[3:0]});
	endtask : st

	task automatic t_states;
		st(dsw_pkg::PWR_NOT_READY, 6'h00);
		st(dsw_pkg::PWR_SWITCH_ON_DISABLED, 6'h20);
		st(dsw_pkg::PWR_READY_TO_SWITCH_ON, 6'h11);
		st(dsw_pkg::PWR_SWITCHED_ON, 6'h13);
		st(dsw_pkg::PWR_OPERATION_ENABLED, 6'h17);
		st(dsw_pkg::PWR_QUICK_STOP_ACTIVE, 6'h07);
		st(dsw_pkg::PWR_FAULT_REACTION, 6'h0F);
		st(dsw_pkg::PWR_FAULT, 6'h08);
		$display("state test done");
	endtask : t_states

	task automatic t_flags;
		@(posedge clock);
		pwr <= dsw_pkg::PWR_OPERATION_ENABLED;
		warn <= 1'h1;
		tick();
		chk("warning flags", 16'h00A7, dsw & 16'hC3FF);
		chk("local control", 16'h0000, cw);
		@(posedge clock);
		warn <= 1'h0;
		mpow <= 1'h1;
		comm <= dsw_pkg::COMM_PRE_OPERATIONAL;
		tick();
		chk("remote flags", 16'h0237, dsw & 16'hC3FF);
		chk("remote control", 16'h000F, cw);
		$display("flag test done");
	endtask : t_flags

	task automatic t_modes;
		logic [15:0] e [9];
		e = '{16'h0, 16'h3400, 16'h1400, 16'h0400, 16'h3400, 16'h1400, 16'h3000, 16'h1000, 16'h1000};
		for (int i = 0; i < 9; i++) begin
			@(posedge clock);
			mode <= dsw_pkg::dsw_mode_e'(i[3:0]);
			mf <= '1;
			tick();
			chk("mode bits", e[i], dsw & 16'h3400);
		end
		$display("mode test done");
	endtask : t_modes

	// Modes by code: 1 position, 2 velocity, 4 homing, 7 cyclic velocity, 8 cyclic torque.
	task automatic lc(input logic [3:0] m, input logic so, input logic [5:0] l,
		input logic [15:0] mx, input logic [15:0] sel, input logic [15:0] tt, input logic e);
		@(posedge clock);
		mode <= dsw_pkg::dsw_mode_e'(m);
		servo <= so;
		lf <= l;
		trq <= '{tt, 16'h0000, mx, 16'h1000, 16'h0100, sel, 16'h0200};
		tick();
		chk("limit flag", {4'h0, e, 11'h000}, dsw & 16'h0800);
	endtask : lc

	task automatic t_limits;
		logic        a;
		logic        er;
		logic [15:0] rd;
		lc(4'h1, 1'h0, 6'h02, 16'h1000, 16'h0, 16'h0, 1'h1);
		lc(4'h7, 1'h0, 6'h02, 16'h1000, 16'h0, 16'h0, 1'h0);
		lc(4'h2, 1'h0, 6'h08, 16'h1000, 16'h0, 16'h0, 1'h1);
		lc(4'h4, 1'h1, 6'h30, 16'h1000, 16'h0, 16'h0, 1'h1);
		lc(4'h4, 1'h0, 6'h30, 16'h1000, 16'h0, 16'h0, 1'h0);
		lc(4'h4, 1'h1, 6'h20, 16'h1000, 16'h0, 16'h0, 1'h0);
		lc(4'h8, 1'h0, 6'h01, 16'h1000, 16'h0, 16'h1000, 1'h0);
		lc(4'h8, 1'h1, 6'h01, 16'h1000, 16'h0, 16'h1000, 1'h1);
		lc(4'h1, 1'h0, 6'h00, 16'h0000, 16'h0, 16'h0, 1'h1);
		lc(4'h1, 1'h1, 6'h00, 16'h1000, 16'h2, 16'h0, 1'h1);
		lc(4'h1, 1'h1, 6'h00, 16'h1000, 16'h4, 16'h0, 1'h1);
		lc(4'h1, 1'h1, 6'h00, 16'h1000, 16'h3, 16'h0, 1'h0);
		lc(4'h8, 1'h1, 6'h00, 16'h1000, 16'h0, 16'h0100, 1'h1);
		mst.access(1'h1, dsw_pkg::IDX_TORQUE_LIMIT_FLAG_SELECT, 16'h0001, a, er, rd);
		chk("select write", 16'h0002, {14'h0000, a, er});
		chk("select value", 16'h0001, {15'h0000, fsel});
		lc(4'h8, 1'h1, 6'h00, 16'h1000, 16'h0, 16'h0100, 1'h0);
		$display("limit test done");
	endtask : t_limits

	task automatic t_objects;
		logic        a;
		logic        er;
		logic [15:0] rd;
		@(posedge clock);
		pwr <= dsw_pkg::PWR_SWITCHED_ON;
		mode <= dsw_pkg::MODE_NONE;
		mst.access(1'h1, dsw_pkg::IDX_TORQUE_LIMIT_FLAG_SELECT, 16'h0002, a, er, rd);
		chk("bad select", 16'h0003, {14'h0000, a, er});
		chk("select kept", 16'h0001, {15'h0000, fsel});
		mst.access(1'h1, dsw_pkg::IDX_DRIVE_STATUS_WORD, 16'hFFFF, a, er, rd);
		chk("word write", 16'h0003, {14'h0000, a, er});
		mst.access(1'h0, dsw_pkg::IDX_DRIVE_STATUS_WORD, 16'h0000, a, er, rd);
		chk("word read", 16'h0233, rd);
		mst.access(1'h0, 16'h1234, 16'h0000, a, er, rd);
		chk("unmapped", 16'h0003, {14'h0000, a, er});
		chk("unmapped data", 16'h0000, rd);
		$display("object test done");
	endtask : t_objects

	task automatic final_report;
		$display("checked %0d mismatched %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	initial begin
		clock = 1'h0;
		srst = 1'h1;
		servo = 1'h0;
		mpow = 1'h0;
		warn = 1'h0;
		pwr = dsw_pkg::PWR_NOT_READY;
		comm = dsw_pkg::COMM_INIT;
		mode = dsw_pkg::MODE_NONE;
		mf = '0;
		lf = '0;
		trq = '{16'h0, 16'h0, 16'h1000, 16'h1000, 16'h1000, 16'h0, 16'h0};
		n_mismatch = 0;
		samples_checked = 0;
		t_reset();
		t_states();
		t_flags();
		t_modes();
		t_limits();
		t_objects();
		t_reset();
		final_report();
	end

	// The whole sequence needs well under 200 cycles; this margin only catches a hang.
	initial begin
		repeat (2000) @(posedge clock);
		n_mismatch++;
		final_report();
	end
endmodule : tb_top

bind dsw_composer dsw_properties chk_i (.clock, .srst, .power_drive_state, .comm_state_machine,
	.main_power_present, .warning_present, .obj_req, .obj_wr, .obj_index, .obj_ack, .obj_err,
	.drive_status_word);
